// *** src/psp_pkg.sv ***
// psp_pkg: constants, types and the ALU function of the program sequencer pipeline.
// assumes a single 250 MHz clock domain and a classic Wishbone register port.
package psp_pkg;

    // ----------------------------------------------------------------
    // register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0] PSP_OFS_PCL = 8'h00;
    localparam logic [7:0] PSP_OFS_CTRL = 8'h04;
    localparam logic [7:0] PSP_OFS_STAT = 8'h08;
    localparam int PSP_CTRL_INT_EN_BIT = 0;
    localparam int PSP_STAT_ACC_LSB = 0;
    localparam int PSP_STAT_FLAG_LSB = 8;
    localparam int PSP_STAT_PC_LSB = 12;

    // ----------------------------------------------------------------
    // reset values and vectors
    // ----------------------------------------------------------------
    localparam logic [11:0] PSP_RESET_VEC = 12'h000;
    localparam logic [7:0] PSP_ACC_RST = 8'h00;
    localparam logic [3:0] PSP_FLAGS_RST = 4'h0;
    localparam logic PSP_INT_EN_RST = 1'b0;

    // ----------------------------------------------------------------
    // status flag positions and phases
    // ----------------------------------------------------------------
    localparam int PSP_FLAG_C = 0;
    localparam int PSP_FLAG_AC = 1;
    localparam int PSP_FLAG_Z = 2;
    localparam int PSP_FLAG_OV = 3;
    localparam logic [1:0] PSP_PH_T1 = 2'h0;
    localparam logic [1:0] PSP_PH_T2 = 2'h1;
    localparam logic [1:0] PSP_PH_T3 = 2'h2;
    localparam logic [1:0] PSP_PH_T4 = 2'h3;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {PSP_SEQ, PSP_JUMP, PSP_CALL, PSP_RET, PSP_RETURN_FROM_INT_INSTR} psp_ctrl_type;
    typedef enum logic [3:0] {
        PSP_PASS, PSP_ADD, PSP_ADC, PSP_SUB, PSP_SBC, PSP_DAA, PSP_AND, PSP_OR,
        PSP_XOR, PSP_CPL, PSP_RR, PSP_RRC, PSP_RL, PSP_RLC, PSP_INC, PSP_DEC
    } psp_alu_op_type;
    typedef enum logic [1:0] {PSP_SKIP_NONE, PSP_SKIP_ZERO, PSP_SKIP_NONZERO} psp_skip_type;

    typedef struct packed {
        psp_ctrl_type ctrl;
        psp_alu_op_type alu_op;
        psp_skip_type skip;
        logic use_mem;
        logic wr_en;
        logic to_mem;
        logic [11:0] target;
        logic [7:0] imm;
    } psp_dec_type;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } psp_wb_req_type;

    typedef struct packed {
        logic [7:0] res;
        logic [3:0] flags;
        logic [3:0] mask;
    } psp_alu_type;

    // ----------------------------------------------------------------
    // alu: a is the accumulator, b the source operand
    // ----------------------------------------------------------------
    function automatic psp_alu_type psp_alu_calc(psp_alu_op_type op, logic [7:0] a, logic [7:0] b,
                                                 logic [3:0] fin);
        psp_alu_type o;
        logic [7:0] bb;
        logic cn;
        logic [8:0] s;
        logic [4:0] h;
        logic [8:0] d;
        o = '0;
        bb = b;
        cn = 1'b0;
        s = '0;
        h = '0;
        d = {1'b0, a};
        o.res = b;
        case (op)
            PSP_ADD, PSP_ADC, PSP_SUB, PSP_SBC:
            begin
                // subtract as a + ~b + 1, so carry set means no borrow
                bb = (op == PSP_SUB || op == PSP_SBC) ? ~b : b;
                cn = (op == PSP_SUB) ? 1'b1 : ((op == PSP_ADD) ? 1'b0 : fin[PSP_FLAG_C]);
                s = {1'b0, a} + {1'b0, bb} + {8'h00, cn};
                h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cn};
                o.res = s[7:0];
                o.flags[PSP_FLAG_C] = s[8];
                o.flags[PSP_FLAG_AC] = h[4];
                o.flags[PSP_FLAG_OV] = (a[7] == bb[7]) && (s[7] != a[7]);
                o.mask = 4'hF;
            end
            PSP_DAA:
            begin
                if (d[3:0] > 4'h9 || fin[PSP_FLAG_AC])
                    d = d + 9'h006;
                if (d[7:4] > 4'h9 || fin[PSP_FLAG_C] || d[8])
                    d = d + 9'h060;
                o.res = d[7:0];
                o.flags[PSP_FLAG_C] = d[8] | fin[PSP_FLAG_C];
                o.mask[PSP_FLAG_C] = 1'b1;
            end
            PSP_AND: begin o.res = a & b; o.mask[PSP_FLAG_Z] = 1'b1; end
            PSP_OR: begin o.res = a | b; o.mask[PSP_FLAG_Z] = 1'b1; end
            PSP_XOR: begin o.res = a ^ b; o.mask[PSP_FLAG_Z] = 1'b1; end
            PSP_CPL: begin o.res = ~b; o.mask[PSP_FLAG_Z] = 1'b1; end
            PSP_RR: o.res = {b[0], b[7:1]};
            PSP_RL: o.res = {b[6:0], b[7]};
            PSP_RRC:
            begin
                o.res = {fin[PSP_FLAG_C], b[7:1]};
                o.flags[PSP_FLAG_C] = b[0];
                o.mask[PSP_FLAG_C] = 1'b1;
            end
            PSP_RLC:
            begin
                o.res = {b[6:0], fin[PSP_FLAG_C]};
                o.flags[PSP_FLAG_C] = b[7];
                o.mask[PSP_FLAG_C] = 1'b1;
            end
            PSP_INC: begin o.res = b + 8'h01; o.mask[PSP_FLAG_Z] = 1'b1; end
            PSP_DEC: begin o.res = b - 8'h01; o.mask[PSP_FLAG_Z] = 1'b1; end
            default: o.res = b;
        endcase
        o.flags[PSP_FLAG_Z] = (o.res == 8'h00);
        return o;
    endfunction : psp_alu_calc

endpackage : psp_pkg

// *** src/psp_sequencer.sv ***
// psp_sequencer: four-phase instruction sequencer with prefetch, return stack and 8-bit alu.
// assumes a synchronous program memory answering one clock after the address and an
// external decoder that turns instr_o into dec_i combinationally within the T2 phase.
`timescale 1ns/100ps

// What this block does
// - four non-overlapping phases from the system clock form one instruction cycle
// - at start of first phase the counter advances and next word is fetched
// - phases two to four decode and execute the previously fetched word
// - fetch overlaps execution, giving one plain instruction per cycle
// - jumps and calls take two cycles: one for the target, one for the branch
// - counter increases by one per instruction unless control moves elsewhere
// - counter is 12 bits: 4 high bits and a software-visible low byte
// - jumps, calls, interrupt entry and reset load the target into the counter
// - a met skip discards the prefetched word and runs a dummy cycle instead
// - low byte readable and writable; a write jumps within the current 256-word page
// - a low byte write costs one dummy cycle for the new prefetch
// - return stack holds only counter values; stack and pointer are hidden from software
// - call or interrupt acknowledge pushes the counter onto the return stack
// - return and return-from-interrupt pop the stack back into the counter
// - after reset the stack pointer marks an empty stack
// - with a full stack an interrupt waits unacknowledged until a return frees a level
// - a call on a full stack still runs, losing the oldest saved value
// - alu works on 8 bits, writes its target and updates status flags
// - add, add with carry, subtract, subtract with borrow and decimal adjust
// - and, or, xor, complement, rotates with and without carry, increment, decrement
// - reset loads address zero and execution starts there
module psp_sequencer
    import psp_pkg::*;
#(
    parameter int STACK_DEPTH = 8,
    parameter int INSTR_W = 16
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input psp_wb_req_type wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // program memory
    output logic [11:0] pm_addr_o,
    output logic pm_rd_o,
    input wire logic [INSTR_W-1:0] pm_data_i,
    // decoder
    output logic [INSTR_W-1:0] instr_o,
    output logic exec_valid_o,
    input psp_dec_type dec_i,
    // data memory operand and result
    input wire logic [7:0] mem_data_i,
    output logic [7:0] res_data_o,
    output logic res_wr_o,
    output logic [7:0] acc_o,
    output logic [3:0] flags_o,
    // interrupt handshake and phases
    input wire logic int_req_i,
    input wire logic [11:0] int_vec_i,
    output logic int_ack_o,
    output logic [3:0] phase_o
);

    localparam int SPW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
    localparam logic [SPW:0] STACK_FULL_CNT = SPW'(STACK_DEPTH) == '0 ? {1'b1, {SPW{1'b0}}} :
                                              {1'b0, SPW'(STACK_DEPTH)};

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [1:0] phase_q;
    logic [3:0] phase_oh_q;
    logic [11:0] pc_q;
    logic [11:0] pc_d;
    logic [11:0] pm_addr_q;
    logic pm_rd_q;
    logic [INSTR_W-1:0] fetch_q;
    logic [INSTR_W-1:0] instr_q;
    logic [11:0] exec_pc_q;
    logic exec_valid_q;
    psp_dec_type dec_q;
    psp_alu_type alu_q;
    logic [7:0] acc_q;
    logic [3:0] flags_q;
    logic [7:0] res_data_q;
    logic res_wr_q;
    logic int_en_q;
    logic int_ack_q;
    logic [7:0] pcl_new_q;
    logic pcl_pend_q;
    logic [11:0] stk_mem [STACK_DEPTH];
    logic [SPW-1:0] sp_q;
    logic [SPW:0] cnt_q;
    logic [31:0] wb_dat_q;
    logic wb_ack_q;

    // ----------------------------------------------------------------
    // commit decisions taken at the end of T4, plus stack status and the bus decode that is not tied to T4
    // ----------------------------------------------------------------
    logic at_t4;
    logic exec_go;
    logic is_branch;
    logic skip_hit;
    logic do_call;
    logic do_pop;
    logic int_take;
    logic pcl_take;
    logic flush;
    logic push;
    logic [11:0] push_val;
    logic stk_full;
    logic stk_empty;
    logic bus_take;
    logic bus_wr;

    assign stk_full = (cnt_q == STACK_FULL_CNT);
    assign stk_empty = (cnt_q == '0);
    assign at_t4 = (phase_q == PSP_PH_T4);
    assign exec_go = at_t4 && exec_valid_q;
    assign do_call = exec_go && (dec_q.ctrl == PSP_CALL);
    assign do_pop = exec_go && (dec_q.ctrl == PSP_RET || dec_q.ctrl == PSP_RETURN_FROM_INT_INSTR);
    assign is_branch = exec_go && (dec_q.ctrl != PSP_SEQ);
    assign skip_hit = exec_go && ((dec_q.skip == PSP_SKIP_ZERO && alu_q.flags[PSP_FLAG_Z]) ||
                                  (dec_q.skip == PSP_SKIP_NONZERO && !alu_q.flags[PSP_FLAG_Z]));
    // a full stack holds the interrupt back; it is taken once a return frees a level
    assign int_take = at_t4 && int_req_i && int_en_q && !stk_full && !is_branch && !skip_hit;
    assign pcl_take = at_t4 && pcl_pend_q && !is_branch && !skip_hit && !int_take;
    assign flush = is_branch || skip_hit || int_take || pcl_take;
    assign push = do_call || int_take;
    // a call returns past itself; an interrupt returns to the discarded prefetch
    assign push_val = do_call ? (exec_pc_q + 12'h001) : pm_addr_q;
    assign bus_take = wb_req_i.cyc && wb_req_i.stb && !wb_ack_q;
    assign bus_wr = bus_take && wb_req_i.we;

    always_comb
    begin
        pc_d = pc_q;
        if (exec_go && (dec_q.ctrl == PSP_JUMP || dec_q.ctrl == PSP_CALL))
            pc_d = dec_q.target;
        else if (do_pop)
            pc_d = stk_mem[sp_q];
        else if (int_take)
            pc_d = int_vec_i;
        else if (pcl_take)
            pc_d = {pc_q[11:8], pcl_new_q};
    end

    // ----------------------------------------------------------------
    // phase generator
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_q <= PSP_PH_T4;
            phase_oh_q <= 4'h0;
        end
        else
        begin
            phase_q <= phase_q + 2'h1;
            phase_oh_q <= 4'h1 << (phase_q + 2'h1);
        end
    end

    // ----------------------------------------------------------------
    // fetch: counter, address and prefetch word
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_q <= PSP_RESET_VEC;
            pm_addr_q <= PSP_RESET_VEC;
            pm_rd_q <= 1'b0;
            fetch_q <= '0;
        end
        else
        begin
            pm_rd_q <= at_t4;
            if (at_t4)
            begin
                pm_addr_q <= pc_d;
                pc_q <= pc_d + 12'h001;
            end
            if (phase_q == PSP_PH_T2)
                fetch_q <= pm_data_i;
        end
    end

    // ----------------------------------------------------------------
    // execute pipe: the prefetched word runs in the next cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            instr_q <= '0;
            exec_pc_q <= PSP_RESET_VEC;
            exec_valid_q <= 1'b0;
            dec_q <= '0;
            alu_q <= '0;
        end
        else
        begin
            if (at_t4)
            begin
                instr_q <= fetch_q;
                exec_pc_q <= pm_addr_q;
                // nothing was fetched before the first phase after reset, so that slot is a dummy
                exec_valid_q <= !flush && phase_oh_q[3];
            end
            if (phase_q == PSP_PH_T2)
                dec_q <= dec_i;
            if (phase_q == PSP_PH_T3)
                alu_q <= psp_alu_calc(dec_q.alu_op, acc_q, dec_q.use_mem ? mem_data_i : dec_q.imm,
                                      flags_q);
        end
    end

    // ----------------------------------------------------------------
    // results: accumulator, memory write and flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc_q <= PSP_ACC_RST;
            flags_q <= PSP_FLAGS_RST;
            res_data_q <= 8'h00;
            res_wr_q <= 1'b0;
        end
        else
        begin
            res_wr_q <= exec_go && dec_q.wr_en && dec_q.to_mem;
            if (exec_go)
            begin
                res_data_q <= alu_q.res;
                if (dec_q.wr_en && !dec_q.to_mem)
                    acc_q <= alu_q.res;
                flags_q <= (flags_q & ~alu_q.mask) | (alu_q.flags & alu_q.mask);
            end
        end
    end

    // ----------------------------------------------------------------
    // return stack: circular, so an overflowing push drops the oldest
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (push)
            stk_mem[SPW'(sp_q + SPW'(1))] <= push_val;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sp_q <= '0;
            cnt_q <= '0;
        end
        else if (push)
        begin
            sp_q <= sp_q + SPW'(1);
            if (!stk_full)
                cnt_q <= cnt_q + 1'b1;
        end
        else if (do_pop)
        begin
            sp_q <= sp_q - SPW'(1);
            if (!stk_empty)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // interrupt enable and acknowledge
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            int_en_q <= PSP_INT_EN_RST;
            int_ack_q <= 1'b0;
        end
        else
        begin
            int_ack_q <= int_take;
            if (bus_wr && wb_req_i.adr == PSP_OFS_CTRL && wb_req_i.sel[0])
                int_en_q <= wb_req_i.dat[PSP_CTRL_INT_EN_BIT];
            else if (int_take)
                int_en_q <= 1'b0;
            else if (exec_go && dec_q.ctrl == PSP_RETURN_FROM_INT_INSTR)
                int_en_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // wishbone slave, one wait state; unmapped reads give zero
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pcl_new_q <= 8'h00;
            pcl_pend_q <= 1'b0;
        end
        else
        begin
            // a new write wins over the take of an older one
            if (bus_wr && wb_req_i.adr == PSP_OFS_PCL && wb_req_i.sel[0])
            begin
                pcl_new_q <= wb_req_i.dat[7:0];
                pcl_pend_q <= 1'b1;
            end
            else if (pcl_take)
                pcl_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_q <= bus_take;
            if (bus_take)
            begin
                wb_dat_q <= 32'h0000_0000;
                // stack pointer and contents are deliberately absent from the map
                unique case (wb_req_i.adr)
                    PSP_OFS_PCL: wb_dat_q[7:0] <= pc_q[7:0];
                    PSP_OFS_CTRL: wb_dat_q[PSP_CTRL_INT_EN_BIT] <= int_en_q;
                    PSP_OFS_STAT:
                    begin
                        wb_dat_q[PSP_STAT_ACC_LSB +: 8] <= acc_q;
                        wb_dat_q[PSP_STAT_FLAG_LSB +: 4] <= flags_q;
                        wb_dat_q[PSP_STAT_PC_LSB +: 12] <= pc_q;
                    end
                    default: wb_dat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_dat_o = wb_dat_q;
    assign wb_ack_o = wb_ack_q;
    assign pm_addr_o = pm_addr_q;
    assign pm_rd_o = pm_rd_q;
    assign instr_o = instr_q;
    assign exec_valid_o = exec_valid_q;
    assign res_data_o = res_data_q;
    assign res_wr_o = res_wr_q;
    assign acc_o = acc_q;
    assign flags_o = flags_q;
    assign int_ack_o = int_ack_q;
    assign phase_o = phase_oh_q;

endmodule : psp_sequencer

// *** sim/psp_sequencer_monitor.sv ***
// psp_sequencer_monitor: port-level checks of phases, fetch, branches, bus and interrupt entry.
// assumes one clock domain and a reset held for at least two cycles.
`timescale 1ns/100ps
module psp_sequencer_monitor
    import psp_pkg::*;
#(
    parameter int STACK_DEPTH = 8,
    parameter int INSTR_W = 16
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input psp_wb_req_type wb_req_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // fetch and decode
    input wire logic [11:0] pm_addr_o,
    input wire logic pm_rd_o,
    input wire logic [INSTR_W-1:0] pm_data_i,
    input wire logic [INSTR_W-1:0] instr_o,
    input wire logic exec_valid_o,
    input psp_dec_type dec_i,
    // data path, interrupt, phase
    input wire logic [7:0] mem_data_i,
    input wire logic [7:0] res_data_o,
    input wire logic res_wr_o,
    input wire logic [7:0] acc_o,
    input wire logic [3:0] flags_o,
    input wire logic int_req_i,
    input wire logic [11:0] int_vec_i,
    input wire logic int_ack_o,
    input wire logic [3:0] phase_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    phase_onehot_a: assert property (!$past(rst_i) |-> $onehot(phase_o))
        else $error("phase not one-hot");
    phase_order_a: assert property (phase_o[0] |=> phase_o[1] ##1 phase_o[2] ##1 phase_o[3] ##1 phase_o[0])
        else $error("phase order broken");
    fetch_strobe_a: assert property (pm_rd_o == phase_o[0])
        else $error("fetch strobe outside first phase");
    cycle_hold_a: assert property (|phase_o[3:1] |-> $stable(pm_addr_o) && $stable(instr_o)
        && $stable(exec_valid_o))
        else $error("fetch or execute word changed mid cycle");
    acc_hold_a: assert property (|phase_o[3:1] |-> $stable(acc_o) && $stable(flags_o))
        else $error("accumulator changed before commit");
    branch_target_a: assert property (phase_o[3] && exec_valid_o && (dec_i.ctrl inside {PSP_JUMP, PSP_CALL})
        |=> pm_addr_o == $past(dec_i.target) && !exec_valid_o)
        else $error("branch target or dummy cycle wrong");
    reset_vector_a: assert property ($fell(rst_i) |=> phase_o == 4'h1 && pm_rd_o && pm_addr_o == 12'h000)
        else $error("no fetch from reset vector");
    int_entry_a: assert property (int_ack_o |-> phase_o[0] && !exec_valid_o && pm_addr_o == $past(int_vec_i))
        else $error("interrupt entry wrong");
    bus_answer_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    cover property (int_ack_o);
    cover property (wb_ack_o && wb_req_i.we);
    cover property (phase_o[0] && !exec_valid_o);
endmodule : psp_sequencer_monitor

bind psp_sequencer psp_sequencer_monitor #(.STACK_DEPTH(STACK_DEPTH), .INSTR_W(INSTR_W)) psp_sequencer_monitor_i (.*);

// *** sim/psp_prog_mem.sv ***
// psp_prog_mem: behavioural program memory answering one clock after the fetch strobe.
// assumes the bench loads words into mem before they are fetched.
`timescale 1ns/100ps
module psp_prog_mem (
    // clock
    input wire logic clk_i,
    // fetch port
    input wire logic [11:0] addr_i,
    input wire logic rd_i,
    output logic [15:0] data_o
);
    logic [15:0] mem [0:4095] = '{default: 16'h0000};

    // word toggles outside its cycle so a late sample cannot pass
    always_ff @(posedge clk_i)
    begin
        if (rd_i)
            data_o <= mem[addr_i];
        else
            data_o <= ~data_o;
    end
endmodule : psp_prog_mem

// *** sim/tb.sv ***
// tb: self-checking bench for psp_sequencer with a program memory model and a table decoder.
// assumes fetch in the first phase and the word sampled at the end of the second.
`timescale 1ns/100ps
module tb
    import psp_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    psp_wb_req_type wb_req_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [11:0] pm_addr_o;
    logic pm_rd_o;
    logic [15:0] pm_data_i;
    logic [15:0] instr_o;
    logic exec_valid_o;
    psp_dec_type dec_i;
    logic [7:0] mem_data_i = 8'h5A;
    logic [7:0] res_data_o;
    logic res_wr_o;
    logic [7:0] acc_o;
    logic [3:0] flags_o;
    logic int_req_i = 1'b0;
    logic [11:0] int_vec_i = 12'h200;
    logic int_ack_o;
    logic [3:0] phase_o;
    int err_total = 0;
    int check_count = 0;
    int n;
    logic [31:0] lfsr = 32'hD16B;
    logic [31:0] q;
    logic [7:0] r [3];
    logic [7:0] e;
    logic [7:0] t;
    logic [7:0] wr_seen = 8'h00;
    logic [11:0] fetch_q [$];
    logic [11:0] exp_f [10] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h100, 12'h101, 12'h102, 12'h103,
        12'h104, 12'h105};

    psp_sequencer psp_sequencer_i (.*);
    psp_prog_mem psp_prog_mem_i (.clk_i(clk_i), .addr_i(pm_addr_o), .rd_i(pm_rd_o), .data_o(pm_data_i));

    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    // top nibble: 1 add imm, 2 jump, 3 call, 4 return, 5 skip if zero, 6 return from int, 7 inc memory
    function automatic psp_dec_type dec_word(logic [15:0] w);
        psp_dec_type d;
        d = '0;
        d.target = w[11:0];
        d.imm = w[7:0];
        case (w[15:12])
            4'h1:
            begin
                d.alu_op = PSP_ADD;
                d.wr_en = 1'b1;
            end
            4'h2: d.ctrl = PSP_JUMP;
            4'h3: d.ctrl = PSP_CALL;
            4'h4: d.ctrl = PSP_RET;
            4'h5: d.skip = PSP_SKIP_ZERO;
            4'h6: d.ctrl = PSP_RETURN_FROM_INT_INSTR;
            4'h7:
            begin
                d.alu_op = PSP_INC;
                d.use_mem = 1'b1;
                d.wr_en = 1'b1;
                d.to_mem = 1'b1;
            end
            default: d.ctrl = PSP_SEQ;
        endcase
        return d;
    endfunction : dec_word

    // flags {OV, Z, AC, C} of a plain add
    function automatic logic [3:0] add_flags(logic [7:0] a, logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
                ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F, s[8]};
    endfunction : add_flags

    always #2 clk_i = ~clk_i;
    always_comb dec_i = dec_word(instr_o);
    always @(posedge clk_i)
        if (pm_rd_o === 1'b1)
            fetch_q.push_back(pm_addr_o);
    always @(posedge clk_i)
        if (res_wr_o === 1'b1)
            wr_seen <= res_data_o;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        chk(n, 2);
        wb_req_i <= '0;
        @(posedge clk_i);
    endtask : wb_xfer

    task automatic wait_addr(input logic [11:0] a);
        n = 0;
        while (!(pm_rd_o === 1'b1 && pm_addr_o === a) && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(n < 200, 1);
    endtask : wait_addr

    task automatic conclude();
        if (err_total == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    initial
    begin
        #20000;
        err_total++;
        conclude();
    end

    initial
    begin
        for (int i = 0; i < 3; i++)
        begin
            lfsr = lfsr_next(lfsr);
            r[i] = lfsr[7:0];
        end
        e = r[0] + r[1] + r[2];
        t = 8'h40 | lfsr[13:8];
        psp_prog_mem_i.mem[0] = {8'h10, r[0]};
        psp_prog_mem_i.mem[1] = {8'h10, r[1]};
        psp_prog_mem_i.mem[2] = 16'h3100;
        psp_prog_mem_i.mem[3] = 16'h2003;
        psp_prog_mem_i.mem[256] = 16'h5000;
        psp_prog_mem_i.mem[257] = 16'h10FF;
        psp_prog_mem_i.mem[258] = 16'h7000;
        psp_prog_mem_i.mem[259] = {8'h10, r[2]};
        psp_prog_mem_i.mem[260] = 16'h4000;
        psp_prog_mem_i.mem[512] = 16'h6000;
        psp_prog_mem_i.mem[{4'h0, t}] = {8'h20, t};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (60) @(posedge clk_i);
        for (int i = 0; i < 10; i++)
            chk(fetch_q[i], exp_f[i]);
        chk(acc_o, e);
        chk(wr_seen, mem_data_i + 8'h01);
        wb_xfer(1'b0, PSP_OFS_STAT, 32'h0);
        chk(q[7:0], e);
        chk(q[PSP_STAT_FLAG_LSB +: 4], add_flags(r[0] + r[1], r[2]));
        wb_xfer(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        wb_xfer(1'b1, PSP_OFS_CTRL, 32'h1);
        wb_xfer(1'b0, PSP_OFS_CTRL, 32'h0);
        chk(q[0], 1'b1);
        wb_xfer(1'b1, PSP_OFS_PCL, {24'h0, t});
        wait_addr({4'h0, t});
        int_req_i <= 1'b1;
        n = 0;
        while (int_ack_o !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        int_req_i <= 1'b0;
        chk(n < 100, 1);
        wait_addr(12'h200);
        wb_xfer(1'b0, PSP_OFS_CTRL, 32'h0);
        chk(q[0], 1'b0);
        wait_addr({4'h0, t});
        wb_xfer(1'b0, PSP_OFS_CTRL, 32'h0);
        chk(q[0], 1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_addr(12'h000);
        wb_xfer(1'b0, PSP_OFS_CTRL, 32'h0);
        chk(q[0], 1'b0);
        conclude();
    end
endmodule : tb
